// ---- logic/gp_pkg.sv ----
// Purpose: Constants for the general purpose port block
// Assumes: AHB-Lite word registers, 250 MHz hclk
// Notes:   Offsets are byte addresses
//
// Overview of operation
// - Per-pin port A wake arm bit
// - Armed falling edge in sleep wakes core
// - Direction 1 input, 0 push-pull output
// - Input pin reads live pin level
// - Output pin reads data latch
// - Pull-high applied only on inputs
// - One bit selects pull strength
// - Direction and pull follow writes immediately
// - Unimplemented bits ignore writes, read zero
// - A6 select: gpio, analog7, compact timer, chip-select
// - A5 select: gpio, analog6, standard timer, clock
// - A3 select: gpio, analog4, standard timer, data-in
// - A1 select: gpio, analog3, compact timer, data-out
// - Reduced variant: A3 one select bit
// - Reduced variant: codes 00/01 both gpio, except A3 where 01 is serial
// - Latch holds; input reads not latched
package gp_pkg;
  localparam int          GP_NPORT        = 8;
  localparam logic [7:0]  GP_OFF_DATA     = 8'h00;
  localparam logic [7:0]  GP_OFF_DIR      = 8'h04;
  localparam logic [7:0]  GP_OFF_PULL     = 8'h08;
  localparam logic [7:0]  GP_PORT_STRIDE  = 8'h10;
  localparam logic [7:0]  GP_OFF_WAKE     = 8'h80;
  localparam logic [7:0]  GP_OFF_FSEL     = 8'h84;
  localparam logic [7:0]  GP_OFF_CTRL     = 8'h88;
  localparam logic [7:0]  GP_OFF_STAT     = 8'h8C;
  localparam logic [7:0]  GP_RST_DATA     = 8'hFF;
  localparam logic [7:0]  GP_RST_DIR      = 8'hFF;
  localparam logic [7:0]  GP_RST_PULL     = 8'h00;
  localparam logic [7:0]  GP_RST_WAKE     = 8'h00;
  localparam logic [7:0]  GP_RST_FSEL     = 8'h00;
  localparam int          GP_CTRL_STRONG  = 0;
  localparam int          GP_CTRL_SLEEP   = 1;
  localparam int          GP_FSEL_A3_HI   = 3;
  typedef enum logic [1:0] {
    GP_FN_GPIO   = 2'b00,
    GP_FN_ANALOG = 2'b01,
    GP_FN_TIMER  = 2'b10,
    GP_FN_SERIAL = 2'b11
  } gp_fn_e;
endpackage : gp_pkg

// ---- logic/gp_port.sv ----
// Purpose: Eight 8-bit GPIO ports with wake-up, pulls and port A mux
// Assumes: AHB-Lite single word transfers, zero wait states
// Notes:   Pin outputs registered; output enables active low, pull enables active high
module gp_port
  import gp_pkg::*;
#(
  parameter bit         REDUCED = 1'b0,
  parameter logic [7:0] PORT_MASK [GP_NPORT] = '{default: 8'hFF}
) (
  // Clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Pads
  input  wire logic [GP_NPORT*8-1:0] pad_in,
  output logic      [GP_NPORT*8-1:0] pad_out,
  output logic      [GP_NPORT*8-1:0] pad_oe_n,
  output logic      [GP_NPORT*8-1:0] pad_pull_en,
  output logic                       pull_strength_select,
  // Port A analog selects
  output logic                       analog_channel_7,
  output logic                       analog_channel_6,
  output logic                       analog_channel_4,
  output logic                       analog_channel_3,
  // Peripheral outputs to pads
  input  wire logic                  compact_timer_output,
  input  wire logic                  standard_timer_output,
  input  wire logic                  serial_chip_select,
  input  wire logic                  serial_chip_select_oe,
  input  wire logic                  serial_clock_out,
  input  wire logic                  serial_clock_oe,
  input  wire logic                  serial_data_in_line,
  input  wire logic                  serial_data_line_oe,
  input  wire logic                  serial_data_out,
  // Port A levels to peripherals
  output logic      [7:0]            port_a_level,
  // Core power state and wake
  input  wire logic                  core_sleep,
  output logic                       wake_request
);
  localparam int NB = GP_NPORT * 8;

  logic [7:0]    data_ff [GP_NPORT];
  logic [7:0]    dir_ff  [GP_NPORT];
  logic [7:0]    pull_ff [GP_NPORT];
  logic [7:0]    wake_arm_bits_ff;
  logic [7:0]    function_select_a_ff;
  logic          strength_ff;
  logic [NB-1:0] pin_sync;
  logic [7:0]    prev_a_ff;
  logic          wr_pend_ff;
  logic [7:0]    wr_addr_ff;
  logic [7:0]    fsel_mask;

  // Bit 3 absent in reduced variant
  assign fsel_mask = REDUCED ? 8'hF7 : 8'hFF;

  gp_sync #(
    .W (NB)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     (pad_in),
    .q     (pin_sync)
  );

  // Address phase capture
  logic addr_ok;
  assign addr_ok = hsel && hready && htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      wr_addr_ff <= haddr;
    end
  end

  // Register writes take effect on the edge that ends the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < GP_NPORT; p++) begin
        data_ff[p] <= GP_RST_DATA & PORT_MASK[p];
      end
    end else if (wr_pend_ff) begin
      for (int p = 0; p < GP_NPORT; p++) begin
        if (wr_addr_ff == GP_OFF_DATA + 8'(p) * GP_PORT_STRIDE) begin
          data_ff[p] <= hwdata[7:0] & PORT_MASK[p];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < GP_NPORT; p++) begin
        dir_ff[p] <= GP_RST_DIR & PORT_MASK[p];
      end
    end else if (wr_pend_ff) begin
      for (int p = 0; p < GP_NPORT; p++) begin
        if (wr_addr_ff == GP_OFF_DIR + 8'(p) * GP_PORT_STRIDE) begin
          dir_ff[p] <= hwdata[7:0] & PORT_MASK[p];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int p = 0; p < GP_NPORT; p++) begin
        pull_ff[p] <= GP_RST_PULL;
      end
    end else if (wr_pend_ff) begin
      for (int p = 0; p < GP_NPORT; p++) begin
        if (wr_addr_ff == GP_OFF_PULL + 8'(p) * GP_PORT_STRIDE) begin
          pull_ff[p] <= hwdata[7:0] & PORT_MASK[p];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_arm_bits_ff     <= GP_RST_WAKE;
      function_select_a_ff <= GP_RST_FSEL;
      strength_ff          <= 1'b0;
    end else if (wr_pend_ff) begin
      if (wr_addr_ff == GP_OFF_WAKE) begin
        wake_arm_bits_ff <= hwdata[7:0] & PORT_MASK[0];
      end else if (wr_addr_ff == GP_OFF_FSEL) begin
        function_select_a_ff <= hwdata[7:0] & fsel_mask;
      end else if (wr_addr_ff == GP_OFF_CTRL) begin
        strength_ff <= hwdata[GP_CTRL_STRONG];
      end
    end
  end

  // Read mux: input pins show live level, outputs show latch
  logic [31:0] nxt_hrdata;
  always_comb begin
    nxt_hrdata = 32'h0000_0000;
    for (int p = 0; p < GP_NPORT; p++) begin
      if (haddr == GP_OFF_DATA + 8'(p) * GP_PORT_STRIDE) begin
        nxt_hrdata[7:0] = ((dir_ff[p] & pin_sync[p*8 +: 8])
                        | (~dir_ff[p] & data_ff[p])) & PORT_MASK[p];
      end else if (haddr == GP_OFF_DIR + 8'(p) * GP_PORT_STRIDE) begin
        nxt_hrdata[7:0] = dir_ff[p];
      end else if (haddr == GP_OFF_PULL + 8'(p) * GP_PORT_STRIDE) begin
        nxt_hrdata[7:0] = pull_ff[p];
      end
    end
    if (haddr == GP_OFF_WAKE) begin
      nxt_hrdata[7:0] = wake_arm_bits_ff;
    end else if (haddr == GP_OFF_FSEL) begin
      nxt_hrdata[7:0] = function_select_a_ff;
    end else if (haddr == GP_OFF_CTRL) begin
      nxt_hrdata[GP_CTRL_STRONG] = strength_ff;
      nxt_hrdata[GP_CTRL_SLEEP]  = core_sleep;
    end else if (haddr == GP_OFF_STAT) begin
      nxt_hrdata[7:0] = pin_sync[7:0];
    end
  end

  // Zero wait states, always OKAY; unmapped reads zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hrdata    <= (addr_ok && !hwrite) ? nxt_hrdata : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Port A mux decode per pin
  function automatic gp_fn_e fn_of(input logic [1:0] code);
    if (REDUCED && code == GP_FN_ANALOG) begin
      return GP_FN_GPIO;
    end
    return gp_fn_e'(code);
  endfunction : fn_of

  gp_fn_e fn_a6;
  gp_fn_e fn_a5;
  gp_fn_e fn_a3;
  gp_fn_e fn_a1;
  assign fn_a6 = fn_of(function_select_a_ff[7:6]);
  assign fn_a5 = fn_of(function_select_a_ff[5:4]);
  assign fn_a1 = fn_of(function_select_a_ff[1:0]);
  // Reduced A3 uses bit 2 alone as gpio or serial
  assign fn_a3 = REDUCED ? (function_select_a_ff[2] ? GP_FN_SERIAL : GP_FN_GPIO)
                         : fn_of(function_select_a_ff[3:2]);

  logic [NB-1:0] nxt_out;
  logic [NB-1:0] nxt_oe_n;
  always_comb begin
    for (int p = 0; p < GP_NPORT; p++) begin
      // Absent pins stay released at their reset level
      nxt_out[p*8 +: 8]  = data_ff[p] | ~PORT_MASK[p];
      nxt_oe_n[p*8 +: 8] = dir_ff[p] | ~PORT_MASK[p];
    end
    // Peripheral functions override latch
    case (fn_a6)
      GP_FN_ANALOG: begin
        nxt_oe_n[6] = 1'b1;
      end
      GP_FN_TIMER: begin
        nxt_out[6]  = compact_timer_output;
        nxt_oe_n[6] = 1'b0;
      end
      GP_FN_SERIAL: begin
        nxt_out[6]  = serial_chip_select;
        nxt_oe_n[6] = ~serial_chip_select_oe;
      end
      default: begin
      end
    endcase
    case (fn_a5)
      GP_FN_ANALOG: begin
        nxt_oe_n[5] = 1'b1;
      end
      GP_FN_TIMER: begin
        nxt_out[5]  = standard_timer_output;
        nxt_oe_n[5] = 1'b0;
      end
      GP_FN_SERIAL: begin
        nxt_out[5]  = serial_clock_out;
        nxt_oe_n[5] = ~serial_clock_oe;
      end
      default: begin
      end
    endcase
    case (fn_a3)
      GP_FN_ANALOG: begin
        nxt_oe_n[3] = 1'b1;
      end
      GP_FN_TIMER: begin
        nxt_out[3]  = standard_timer_output;
        nxt_oe_n[3] = 1'b0;
      end
      GP_FN_SERIAL: begin
        nxt_out[3]  = serial_data_in_line;
        nxt_oe_n[3] = ~serial_data_line_oe;
      end
      default: begin
      end
    endcase
    case (fn_a1)
      GP_FN_ANALOG: begin
        nxt_oe_n[1] = 1'b1;
      end
      GP_FN_TIMER: begin
        nxt_out[1]  = compact_timer_output;
        nxt_oe_n[1] = 1'b0;
      end
      GP_FN_SERIAL: begin
        nxt_out[1]  = serial_data_out;
        nxt_oe_n[1] = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // Pad drive registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_out <= '1;
    end else begin
      pad_out <= nxt_out;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_oe_n <= '1;
    end else begin
      pad_oe_n <= nxt_oe_n;
    end
  end

  // Pull moves on the same edge as the enable, never on a driven pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_pull_en <= '0;
    end else begin
      for (int p = 0; p < GP_NPORT; p++) begin
        pad_pull_en[p*8 +: 8] <= pull_ff[p] & nxt_oe_n[p*8 +: 8];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pull_strength_select <= 1'b0;
    end else begin
      pull_strength_select <= strength_ff;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_channel_7 <= 1'b0;
      analog_channel_6 <= 1'b0;
      analog_channel_4 <= 1'b0;
      analog_channel_3 <= 1'b0;
      port_a_level     <= 8'h00;
    end else begin
      analog_channel_7 <= (fn_a6 == GP_FN_ANALOG);
      analog_channel_6 <= (fn_a5 == GP_FN_ANALOG);
      analog_channel_4 <= (fn_a3 == GP_FN_ANALOG);
      analog_channel_3 <= (fn_a1 == GP_FN_ANALOG);
      port_a_level     <= pin_sync[7:0];
    end
  end

  // Wake on armed high-to-low edge while asleep
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_a_ff    <= 8'hFF;
      wake_request <= 1'b0;
    end else begin
      prev_a_ff    <= pin_sync[7:0];
      wake_request <= core_sleep && |(prev_a_ff & ~pin_sync[7:0] & wake_arm_bits_ff);
    end
  end
endmodule : gp_port

// ---- logic/gp_sync.sv ----
// Purpose: Two-flop synchroniser for a bus of pin levels
// Assumes: Inputs asynchronous to clk
// Notes:   First stage read only by second stage
module gp_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : gp_sync

// ---- verification/gp_pad_model.sv ----
// Purpose: Switches and signals outside the 64 pins
// Assumes: A strong external drive beats a device output
// Notes:   Floating pins toggle each cycle, never a steady level
module gp_pad_model
  import gp_pkg::*;
(
  // Clock
  input  wire logic                  clk,
  // Device side
  input  wire logic [GP_NPORT*8-1:0] pad_out,
  input  wire logic [GP_NPORT*8-1:0] pad_oe_n,
  input  wire logic [GP_NPORT*8-1:0] pad_pull_en,
  // Switches
  input  wire logic [GP_NPORT*8-1:0] ext_en,
  input  wire logic [GP_NPORT*8-1:0] ext_val,
  output logic      [GP_NPORT*8-1:0] pad_in
);
  logic [GP_NPORT*8-1:0] flt_ff = '0;
  always @(posedge clk) flt_ff <= ~flt_ff;
  assign pad_in = (ext_en & ext_val)
                | (~ext_en & ~pad_oe_n & pad_out)
                | (~ext_en & pad_oe_n & pad_pull_en)
                | (~ext_en & pad_oe_n & ~pad_pull_en & flt_ff);
endmodule : gp_pad_model

// ---- verification/gp_port_asserts.sv ----
// Purpose: Port-level checks for gp_port
// Assumes: One hclk domain, async active-low reset
// Notes:   Hold checks skip port A, whose pads follow the mux
module gp_port_asserts
  import gp_pkg::*;
(
  // Clock and reset
  input wire logic                  hclk,
  input wire logic                  hresetn,
  // Bus
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  // Pads
  input wire logic [GP_NPORT*8-1:0] pad_in,
  input wire logic [GP_NPORT*8-1:0] pad_out,
  input wire logic [GP_NPORT*8-1:0] pad_oe_n,
  input wire logic [GP_NPORT*8-1:0] pad_pull_en,
  input wire logic                  analog_channel_7,
  input wire logic                  analog_channel_6,
  input wire logic                  analog_channel_4,
  input wire logic                  analog_channel_3,
  // Levels and wake
  input wire logic [7:0]            port_a_level,
  input wire logic                  core_sleep,
  input wire logic                  wake_request
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_take;
  assign wr_take = hsel && hready && htrans[1] && hwrite;

  a_pull_input_only: assert property (
    (pad_pull_en & ~pad_oe_n) == '0) else $error("pull-high on a driven pin");
  a_wake_one_pulse: assert property (
    wake_request |=> !wake_request) else $error("wake request longer than one cycle");
  a_wake_in_sleep: assert property (
    wake_request |-> $past(core_sleep)) else $error("wake request while awake");
  a_an7_released: assert property (
    analog_channel_7 |-> pad_oe_n[6]) else $error("A6 driven in analog mode");
  a_an6_released: assert property (
    analog_channel_6 |-> pad_oe_n[5]) else $error("A5 driven in analog mode");
  a_an4_released: assert property (
    analog_channel_4 |-> pad_oe_n[3]) else $error("A3 driven in analog mode");
  a_an3_released: assert property (
    analog_channel_3 |-> pad_oe_n[1]) else $error("A1 driven in analog mode");
  a_level_follows: assert property (
    $stable(pad_in[7:0])[*4] |-> port_a_level == pad_in[7:0]) else $error("port A level lags");
  a_latch_holds: assert property (
    (!wr_take)[*3] |=> $stable(pad_out[63:8])) else $error("pad output moved without a write");
  a_cfg_holds: assert property (
    (!wr_take)[*3] |=> $stable(pad_oe_n[63:8]) && $stable(pad_pull_en[63:8]))
    else $error("pin config moved without a write");
endmodule : gp_port_asserts

bind gp_port gp_port_asserts u_asserts (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
  .analog_channel_7(analog_channel_7), .analog_channel_6(analog_channel_6),
  .analog_channel_4(analog_channel_4), .analog_channel_3(analog_channel_3),
  .port_a_level(port_a_level), .core_sleep(core_sleep), .wake_request(wake_request)
);

// ---- verification/gp_port_bench.sv ----
// Purpose: Self-checking bench for gp_port
// Assumes: Zero wait AHB-Lite slave, port C bits 7:3 absent
// Notes:   Bus waits bounded at 50 cycles
module gp_port_bench;
  import gp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, core_sleep, wake_request;
  logic        pull_strength_select, analog_channel_7, analog_channel_6, analog_channel_4, analog_channel_3;
  logic        compact_timer_output, standard_timer_output, serial_chip_select, serial_chip_select_oe;
  logic        serial_clock_out, serial_clock_oe, serial_data_in_line, serial_data_line_oe, serial_data_out;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  haddr, port_a_level;
  logic [31:0] hwdata, hrdata;
  logic [63:0] pad_in, pad_out, pad_oe_n, pad_pull_en, ext_en, ext_val;
  int          error_cnt, total_checks;
  logic [31:0] hrdata_r, q_red;
  logic [63:0] pad_out_r, oe_r;
  logic [3:0]  an_r;

  assign hready = hreadyout;
  always #2 hclk = ~hclk;

  gp_port #(.PORT_MASK('{8'hff, 8'hff, 8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff})) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
    .pull_strength_select(pull_strength_select), .analog_channel_7(analog_channel_7),
    .analog_channel_6(analog_channel_6), .analog_channel_4(analog_channel_4), .analog_channel_3(analog_channel_3),
    .compact_timer_output(compact_timer_output), .standard_timer_output(standard_timer_output),
    .serial_chip_select(serial_chip_select), .serial_chip_select_oe(serial_chip_select_oe),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .serial_data_in_line(serial_data_in_line), .serial_data_line_oe(serial_data_line_oe),
    .serial_data_out(serial_data_out), .port_a_level(port_a_level),
    .core_sleep(core_sleep), .wake_request(wake_request));
  // Reduced variant shares the bus; only its read data, port A pads and analog selects are watched
  gp_port #(.REDUCED(1'b1)) dut_red (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata_r), .hreadyout(), .hresp(),
    .pad_in(pad_in), .pad_out(pad_out_r), .pad_oe_n(oe_r), .pad_pull_en(), .pull_strength_select(),
    .analog_channel_7(an_r[3]), .analog_channel_6(an_r[2]), .analog_channel_4(an_r[1]), .analog_channel_3(an_r[0]),
    .compact_timer_output(compact_timer_output), .standard_timer_output(standard_timer_output),
    .serial_chip_select(serial_chip_select), .serial_chip_select_oe(serial_chip_select_oe),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .serial_data_in_line(serial_data_in_line), .serial_data_line_oe(serial_data_line_oe),
    .serial_data_out(serial_data_out), .port_a_level(),
    .core_sleep(core_sleep), .wake_request());
  gp_pad_model u_pads (.clk(hclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pull_en(pad_pull_en),
                       .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Address phase held until hready, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    q = hrdata;
    q_red = hrdata_r;
    if (n >= 50) begin
      error_cnt++;
      end_sim();
    end
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0000_0000, q);
    chk(nm, e, q);
  endtask : rdchk

  // Pad outputs land one edge after the data phase
  task automatic settle();
    repeat (2) @(negedge hclk);
  endtask : settle

  task automatic count_wake(output int n);
    n = 0;
    repeat (8) begin
      @(negedge hclk);
      if (wake_request === 1'b1) n++;
    end
    @(posedge hclk);
  endtask : count_wake

  task automatic t_reset();
    chk("pad_out", 32'hffff_ffff, pad_out[31:0]);
    rdchk("dir_a", GP_OFF_DIR, 32'h0000_00ff);
    rdchk("pull_a", GP_OFF_PULL, 32'h0000_0000);
    rdchk("wake", GP_OFF_WAKE, 32'h0000_0000);
    rdchk("fsel", GP_OFF_FSEL, 32'h0000_0000);
    rdchk("unmapped", 8'hfc, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_inout();
    ext_en[15:8]  <= 8'hff;
    ext_val[15:8] <= 8'h3c;
    wr(8'h10, 32'h0000_00a5);
    repeat (4) @(posedge hclk);
    rdchk("in_b", 8'h10, 32'h0000_003c);
    wr(8'h14, 32'h0000_0000);
    settle();
    chk("oe_b", 32'h0000_0000, {24'h0, pad_oe_n[15:8]});
    chk("out_b", 32'h0000_00a5, {24'h0, pad_out[15:8]});
    rdchk("latch_b", 8'h10, 32'h0000_00a5);
    $display("test in/out done");
  endtask : t_inout

  task automatic t_pull();
    wr(8'h28, 32'h0000_00ff);
    wr(8'h24, 32'h0000_00fc);
    settle();
    chk("pull_c", 32'h0000_0004, {24'h0, pad_pull_en[23:16]});
    rdchk("dir_c", 8'h24, 32'h0000_0004);
    wr(GP_OFF_CTRL, 32'h0000_0001);
    settle();
    chk("strength", 32'h0000_0001, {31'h0, pull_strength_select});
    $display("test pull done");
  endtask : t_pull

  task automatic t_wake();
    int n;
    @(posedge hclk);
    ext_en[7:0]  <= 8'hff;
    ext_val[7:0] <= 8'hff;
    core_sleep   <= 1'b1;
    wr(GP_OFF_WAKE, 32'h0000_0004);
    ext_val[0] <= 1'b0;
    count_wake(n);
    chk("wake_unarmed", 32'h0000_0000, n);
    ext_val[2] <= 1'b0;
    count_wake(n);
    chk("wake_armed", 32'h0000_0001, n);
    rdchk("status", GP_OFF_STAT, 32'h0000_00fa);
    core_sleep <= 1'b0;
    ext_val[2] <= 1'b1;
    count_wake(n);
    ext_val[2] <= 1'b0;
    count_wake(n);
    chk("wake_awake", 32'h0000_0000, n);
    $display("test wake done");
  endtask : t_wake

  task automatic t_mux();
    // Distinct levels per source so a wrong route shows
    {compact_timer_output, standard_timer_output, serial_chip_select, serial_chip_select_oe, serial_clock_out,
     serial_clock_oe, serial_data_in_line, serial_data_line_oe, serial_data_out} <= 9'h136;
    wr(GP_OFF_DATA, 32'h0000_0000);
    wr(GP_OFF_DIR, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      wr(GP_OFF_FSEL, {24'h0, {4{c[1:0]}}});
      settle();
      chk("mux", {20'h0, (c == 1) ? 4'hf : (c == 3) ? 4'h4 : 4'h0, (c == 2) ? 4'h9 : (c == 3) ? 4'h6 : 4'h0,
          (c == 1) ? 4'hf : 4'h0},
          {20'h0, pad_oe_n[6], pad_oe_n[5], pad_oe_n[3], pad_oe_n[1],
           (c == 1) ? 4'h0 : {pad_out[6], pad_out[5], pad_out[3], pad_out[1]},
           analog_channel_7, analog_channel_6, analog_channel_4, analog_channel_3});
    end
    $display("test mux done");
  endtask : t_mux

  task automatic t_reduced();
    wr(GP_OFF_FSEL, 32'h0000_00ff);
    rdchk("fsel_full", GP_OFF_FSEL, 32'h0000_00ff);
    chk("fsel_red", 32'h0000_00f7, q_red);
    wr(GP_OFF_FSEL, 32'h0000_0055);
    settle();
    chk("mux_red", 32'h0000_0002, {20'h0, an_r, oe_r[6], oe_r[5], oe_r[3], oe_r[1],
        pad_out_r[6], pad_out_r[5], pad_out_r[3], pad_out_r[1]});
    $display("test reduced done");
  endtask : t_reduced

  initial begin
    {hclk, hresetn, hsel, hwrite, core_sleep} = '0;
    {compact_timer_output, standard_timer_output, serial_chip_select, serial_chip_select_oe,
     serial_clock_out, serial_clock_oe, serial_data_in_line, serial_data_line_oe, serial_data_out} = '0;
    {htrans, haddr, hwdata, ext_en, ext_val} = '0;
    hsize = 3'b010;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_inout();
    t_pull();
    t_wake();
    t_mux();
    t_reduced();
    end_sim();
  end
endmodule : gp_port_bench
